/* File: bench/host_model.sv */
// Host model: free-running converter clock, trigger and serial frames.
// Assumes four clk_i per converter clock; the converter clock runs free.
module host_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic serial_out_a_i,
   input wire logic serial_out_b_i,
   output logic ext_clock_o,
   output logic conversion_trigger_o,
   output logic chip_select_n_o,
   output logic read_strobe_o,
   output logic serial_in_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph_r;
   initial begin
      conversion_trigger_o = 1'b0;
      chip_select_n_o = 1'b1;
      read_strobe_o = 1'b0;
      serial_in_o = 1'b0;
   end
   // Reset keeps the clock low at release
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) ph_r <= 2'h0;
      else ph_r <= ph_r + 2'h1;
   end
   assign ext_clock_o = ph_r[1];
   // Phase 2 edge is a clock rise, phase 0 a clock fall
   task automatic edge_at(input logic [1:0] p);
      do @(posedge clk_i); while (ph_r != p);
   endtask
   task automatic convert();
      edge_at(2'h1);
      conversion_trigger_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      conversion_trigger_o <= 1'b0;
   endtask
   task automatic read_frame(input logic cs_n, input logic [15:0] w, output logic [23:0] a,
      output logic [23:0] b);
      edge_at(2'h2);
      chip_select_n_o <= cs_n;
      edge_at(2'h2);
      read_strobe_o <= 1'b1;
      for (int i = 0; i < 24; i++) begin
         edge_at(2'h2);
         read_strobe_o <= 1'b0;
         serial_in_o <= (i < 16) ? w[15-i] : ~serial_in_o;
         edge_at(2'h0);
         a[23-i] = serial_out_a_i;
         b[23-i] = serial_out_b_i;
      end
      chip_select_n_o <= 1'b1;
   endtask
endmodule

/* File: bench/sar_ctrl_chk.sv */
// Port checker for the dual SAR serial controller.
// Assumes it is bound to the controller and samples the same clk_i edges.
module sar_ctrl_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ext_clock_i,
   input wire logic conversion_trigger_i,
   input wire logic chip_select_n_i,
   input wire logic output_select_pin_i,
   input wire logic automatic_standby_i,
   input wire logic sample_hold_o,
   input wire logic busy_o,
   input wire logic serial_out_a_o,
   input wire logic serial_out_a_oe_o,
   input wire logic serial_out_b_o,
   input wire logic serial_out_b_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import sar_adc_pkg::*;
   logic ext_q_r;
   logic [4:0] rise_cnt_r;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Saturates so a long full-buffer stall cannot wrap
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ext_q_r <= 1'b0;
         rise_cnt_r <= 5'h00;
      end else begin
         ext_q_r <= ext_clock_i;
         if (!sample_hold_o) rise_cnt_r <= 5'h00;
         else if (ext_clock_i && !ext_q_r && rise_cnt_r != 5'h1f) rise_cnt_r <= rise_cnt_r + 5'h01;
      end
   end
   sequence s_trig_taken;
      $rose(conversion_trigger_i) && !sample_hold_o && !busy_o;
   endsequence
   sequence s_after_rise;
      $past(ext_clock_i) && !$past(ext_clock_i, 2);
   endsequence
   property p_hold_on_trig;
      s_trig_taken |=> sample_hold_o;
   endproperty
   a_hold_on_trig: assert property (p_hold_on_trig) else $error("no hold after trigger");
   property p_busy_on_trig;
      s_trig_taken ##0 !automatic_standby_i |=> busy_o;
   endproperty
   a_busy_on_trig: assert property (p_busy_on_trig) else $error("no busy after trigger");
   property p_busy_standby;
      s_trig_taken ##0 automatic_standby_i |=> !busy_o;
   endproperty
   a_busy_standby: assert property (p_busy_standby) else $error("busy early in standby");
   property p_busy_in_hold;
      busy_o |-> sample_hold_o;
   endproperty
   a_busy_in_hold: assert property (p_busy_in_hold) else $error("busy outside hold");
   property p_busy_fall;
      $fell(busy_o) |-> s_after_rise;
   endproperty
   a_busy_fall: assert property (p_busy_fall) else $error("busy fell off clock rise");
   property p_conv_len;
      $fell(sample_hold_o) |-> $fell(busy_o) && rise_cnt_r >= 5'(CONV_CYCLES + 1);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion too short");
   property p_out_enable;
      serial_out_a_oe_o == !$past(chip_select_n_i) && serial_out_b_oe_o == serial_out_a_oe_o;
   endproperty
   a_out_enable: assert property (p_out_enable) else $error("output enable wrong");
   property p_b_idle;
      !output_select_pin_i [*2] |-> !serial_out_b_o;
   endproperty
   a_b_idle: assert property (p_b_idle) else $error("second output not idle");
   property p_a_change;
      $changed(serial_out_a_o) && serial_out_a_oe_o && $past(serial_out_a_oe_o) |-> s_after_rise;
   endproperty
   a_a_change: assert property (p_a_change) else $error("output bit moved off rise");
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the dual SAR serial controller with a host model.
// Assumes the package, the FIFO, the SAR core and the controller compile first.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sar_adc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic in_sel = 1'b0;
   logic out_sel = 1'b0;
   logic standby = 1'b0;
   logic [1:0][11:0] lvl0 = '0;
   logic [1:0][11:0] lvl1 = '0;
   logic ext, trig, cs_n, strobe, serial_in, sh, busy, sa, sb;
   logic aoe, boe, pin_a, pin_b, wvalid;
   int words = 0;
   logic [SDI_BITS-1:0] word;
   int err_total = 0;
   int compares = 0;
   result_pair_type q[$];
   always #20 clk_i = ~clk_i;
   // A released pin reads inverted, so a late enable corrupts the host's bits
   assign pin_a = aoe ? sa : ~sa;
   assign pin_b = boe ? sb : ~sb;
   always @(posedge clk_i) begin
      if (wvalid === 1'b1) words++;
   end
   host_model h (.clk_i(clk_i), .rst_i(rst_i), .serial_out_a_i(pin_a), .serial_out_b_i(pin_b), .ext_clock_o(ext),
      .conversion_trigger_o(trig), .chip_select_n_o(cs_n), .read_strobe_o(strobe), .serial_in_o(serial_in));
   dual_sar_adc_serial_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .ext_clock_i(ext), .conversion_trigger_i(trig),
      .chip_select_n_i(cs_n), .read_strobe_i(strobe), .serial_in_i(serial_in), .input_select_pin_i(in_sel),
      .output_select_pin_i(out_sel), .automatic_standby_i(standby), .channel0_level_i(lvl0),
      .channel1_level_i(lvl1), .sample_hold_o(sh), .busy_o(busy), .serial_out_a_o(sa), .serial_out_a_oe_o(aoe),
      .serial_out_b_o(sb), .serial_out_b_oe_o(boe), .serial_in_word_o(word), .serial_in_word_valid_o(wvalid));
   function automatic result_pair_type expect_pair(input logic s, input logic [1:0][11:0] l0,
      input logic [1:0][11:0] l1);
      return s ? {l1[0], l1[1]} : {l0[0], l0[1]};
   endfunction
   task automatic check_data(input string what, input logic [23:0] exp, input logic [23:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_flag(input string what, input logic exp, input logic got);
      check_data(what, 24'(exp), 24'(got));
   endtask
   task automatic results();
      $display("Counts: %0d compares, %0d mismatches", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_idle(output int rises);
      rises = 0;
      for (int n = 0; n < 150 && sh === 1'b1; n++) begin
         @(posedge clk_i);
         if (h.ph_r == 2'h2) rises++;
      end
   endtask
   task automatic one_conv(input bit stall);
      logic [23:0] r0, r1;
      logic s;
      int rises;
      r0 = 24'($urandom);
      r1 = 24'($urandom);
      s = 1'($urandom);
      @(posedge clk_i);
      lvl0 <= r0;
      lvl1 <= r1;
      in_sel <= s;
      standby <= 1'($urandom);
      q.push_back(expect_pair(s, r0, r1));
      h.convert();
      wait_idle(rises);
      if (stall) check_flag("busy while full", 1'b1, busy);
      else check_data("clock rises in hold", 24'(CONV_CYCLES + 1), 24'(rises));
   endtask
   task automatic one_read(input bit cs_n);
      logic m;
      logic [SDI_BITS-1:0] w;
      logic [23:0] a, b;
      result_pair_type e;
      int n;
      m = 1'($urandom);
      w = 16'($urandom);
      n = words;
      @(posedge clk_i);
      out_sel <= m;
      h.read_frame(cs_n, w, a, b);
      check_data("serial in word pulses", 24'(!cs_n), 24'(words - n));
      if (cs_n) return;
      e = (q.size() > 0) ? q.pop_front() : '0;
      check_data("serial out a", m ? {e.a, 12'h000} : e, a);
      check_data("serial out b", m ? {e.b, 12'h000} : 24'h00_0000, b);
      check_data("serial in word", 24'(w), 24'(word));
   endtask
   initial begin
      int rises;
      void'($urandom(42519));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check_flag("busy after reset", 1'b0, busy);
      for (int i = 0; i < 8; i++) begin
         one_conv(0);
         one_read(0);
      end
      $display("test random pairs done");
      for (int i = 0; i < 16; i++) one_conv(0);
      one_conv(1);
      one_read(1);
      one_read(0);
      wait_idle(rises);
      for (int i = 0; i < 17; i++) one_read(0);
      $display("test full buffer done");
      results();
   end
   // Run needs about 4400 clocks; allow eleven times that
   initial begin
      #2_000_000;
      err_total++;
      results();
   end
endmodule
bind dual_sar_adc_serial_ctrl sar_ctrl_chk CHK (.clk_i(clk_i), .rst_i(rst_i), .ext_clock_i(ext_clock_i),
   .conversion_trigger_i(conversion_trigger_i), .chip_select_n_i(chip_select_n_i),
   .output_select_pin_i(output_select_pin_i), .automatic_standby_i(automatic_standby_i),
   .sample_hold_o(sample_hold_o), .busy_o(busy_o), .serial_out_a_o(serial_out_a_o),
   .serial_out_a_oe_o(serial_out_a_oe_o), .serial_out_b_o(serial_out_b_o), .serial_out_b_oe_o(serial_out_b_oe_o));

/* File: rtl/dual_sar_adc_serial_ctrl.sv */
// Conversion sequencing and serial result port of a dual simultaneous SAR pair.
// Assumes all pins, the external converter clock included, are synchronous to clk_i
// and that the external clock runs well below half of clk_i.
module dual_sar_adc_serial_ctrl #(
   parameter int RES_BITS = sar_adc_pkg::RES_BITS,
   parameter int FIFO_DEPTH = sar_adc_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ext_clock_i,
   input wire logic conversion_trigger_i,
   input wire logic chip_select_n_i,
   input wire logic read_strobe_i,
   input wire logic serial_in_i,
   input wire logic input_select_pin_i,
   input wire logic output_select_pin_i,
   input wire logic automatic_standby_i,
   input wire logic [sar_adc_pkg::CHANNELS-1:0][RES_BITS-1:0] channel0_level_i,
   input wire logic [sar_adc_pkg::CHANNELS-1:0][RES_BITS-1:0] channel1_level_i,
   output logic sample_hold_o,
   output logic busy_o,
   output logic serial_out_a_o,
   output logic serial_out_a_oe_o,
   output logic serial_out_b_o,
   output logic serial_out_b_oe_o,
   output logic [sar_adc_pkg::SDI_BITS-1:0] serial_in_word_o,
   output logic serial_in_word_valid_o
);
   import sar_adc_pkg::*;

   localparam int PAIR_W = 2 * RES_BITS;

   // Edge detection of the external clock and the trigger
   logic ext_clock_r;
   logic trigger_r;
   logic ext_rise;
   logic ext_fall;
   logic trigger_rise;

   assign ext_rise = ext_clock_i && !ext_clock_r;
   assign ext_fall = !ext_clock_i && ext_clock_r;
   assign trigger_rise = conversion_trigger_i && !trigger_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ext_clock_r <= 1'b0;
         trigger_r <= 1'b0;
      end else begin
         ext_clock_r <= ext_clock_i;
         trigger_r <= conversion_trigger_i;
      end
   end

   // Conversion sequencer
   conv_state_type state_r;
   conv_state_type state_nxt;
   logic [3:0] conv_cnt_r;
   logic [1:0] acq_cnt_r;
   logic [CHANNELS-1:0][RES_BITS-1:0] held_r;
   logic [CHANNELS-1:0][RES_BITS-1:0] sar_result;
   logic sar_load;
   logic sar_step;
   logic conv_last;
   logic push_valid;
   logic push_ready;
   logic trigger_ok;

   // Triggers during hold, conversion or stall leave no trace
   assign trigger_ok = trigger_rise && ((state_r == ST_IDLE) || (state_r == ST_ACQUIRE));
   assign conv_last = (conv_cnt_r == 4'(CONV_CYCLES));
   assign sar_load = (state_r == ST_HOLD) && ext_rise;
   assign sar_step = (state_r == ST_CONVERT) && ext_rise && !conv_last;
   // Result leaves only when the FIFO has room; a full FIFO keeps busy high
   assign push_valid = ((state_r == ST_CONVERT) && conv_last) || (state_r == ST_STALL);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (trigger_ok) begin
               state_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (ext_rise) begin
               state_nxt = ST_CONVERT;
            end
         end
         ST_CONVERT: begin
            if (ext_rise && conv_last) begin
               state_nxt = push_ready ? ST_ACQUIRE : ST_STALL;
            end
         end
         ST_STALL: begin
            if (ext_rise && push_ready) begin
               state_nxt = ST_ACQUIRE;
            end
         end
         ST_ACQUIRE: begin
            if (trigger_ok) begin
               state_nxt = ST_HOLD;
            end else if (ext_rise && (acq_cnt_r == 2'(ACQ_CYCLES - 1))) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Load rise is cycle one, so the push lands on the fourteenth rise
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         conv_cnt_r <= CONV_CNT_RST;
      end else if (sar_load) begin
         conv_cnt_r <= 4'h1;
      end else if (sar_step) begin
         conv_cnt_r <= conv_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acq_cnt_r <= ACQ_CNT_RST;
      end else if (state_r != ST_ACQUIRE) begin
         acq_cnt_r <= ACQ_CNT_RST;
      end else if (ext_rise) begin
         acq_cnt_r <= acq_cnt_r + 2'h1;
      end
   end

   // Sample captured on the trigger edge itself, without waiting for a clock edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         held_r <= '0;
      end else if (trigger_ok) begin
         held_r <= input_select_pin_i ? channel1_level_i : channel0_level_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sample_hold_o <= 1'b0;
      end else if (trigger_ok) begin
         sample_hold_o <= 1'b1;
      end else if (ext_rise && push_valid && push_ready) begin
         sample_hold_o <= 1'b0;
      end
   end

   // In standby the front end is asleep, so busy waits for the first clock rise
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
      end else if (trigger_ok && !automatic_standby_i) begin
         busy_o <= 1'b1;
      end else if (sar_load) begin
         busy_o <= 1'b1;
      end else if (ext_rise && push_valid && push_ready) begin
         busy_o <= 1'b0;
      end
   end

   sar_core #(
      .RES_BITS(RES_BITS),
      .CHANNELS(CHANNELS)
   ) u_sar (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(sar_load),
      .step_i(sar_step),
      .held_i(held_r),
      .result_o(sar_result)
   );

   // Result buffer between converter and serial port
   logic [PAIR_W-1:0] head_word;
   logic head_valid;
   logic pop;
   result_pair_type push_pair;

   assign push_pair.a = sar_result[0];
   assign push_pair.b = sar_result[1];

   result_fifo #(
      .WIDTH(PAIR_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_data_i(push_pair),
      .wr_valid_i(push_valid && ext_rise),
      .wr_ready_o(push_ready),
      .rd_data_o(head_word),
      .rd_valid_o(head_valid),
      .rd_ready_i(pop)
   );

   // Serial frame control
   logic frame_start;
   logic [FRAME_BITS-1:0] shift_a_r;
   logic [RES_BITS-1:0] shift_b_r;
   logic [FRAME_BITS-1:0] load_a;
   result_pair_type head_pair;

   assign head_pair = head_word;
   assign frame_start = ext_fall && !chip_select_n_i && read_strobe_i;
   // Empty buffer still frames; the host reads zeros
   assign pop = frame_start && head_valid;
   assign load_a = output_select_pin_i ? {head_pair.a, {RES_BITS{1'b0}}} : {head_pair.a, head_pair.b};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_a_r <= '0;
         shift_b_r <= '0;
      end else if (frame_start) begin
         shift_a_r <= head_valid ? load_a : '0;
         shift_b_r <= (head_valid && output_select_pin_i) ? head_pair.b : '0;
      end else if (ext_rise) begin
         shift_a_r <= shift_a_r << 1;
         shift_b_r <= shift_b_r << 1;
      end
   end

   // Bits move only on external rises so they are settled at the next fall
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_out_a_o <= 1'b0;
      end else if (ext_rise) begin
         serial_out_a_o <= shift_a_r[FRAME_BITS-1];
      end
   end

   // Parks low at once on leaving parallel mode, not at the next rise
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_out_b_o <= 1'b0;
      end else if (!output_select_pin_i) begin
         serial_out_b_o <= 1'b0;
      end else if (ext_rise) begin
         serial_out_b_o <= shift_b_r[RES_BITS-1];
      end
   end

   // Enables lag chip select by one clock, well inside the host's setup
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_out_a_oe_o <= 1'b0;
         serial_out_b_oe_o <= 1'b0;
      end else begin
         serial_out_a_oe_o <= !chip_select_n_i;
         serial_out_b_oe_o <= !chip_select_n_i;
      end
   end

   // Serial input capture
   // Chip select high abandons a part-received word
   logic [SDI_BITS-1:0] sdi_shift_r;
   logic [4:0] sdi_cnt_r;
   logic sdi_active_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sdi_active_r <= 1'b0;
         sdi_cnt_r <= SDI_CNT_RST;
         sdi_shift_r <= '0;
      end else if (frame_start) begin
         sdi_active_r <= 1'b1;
         sdi_cnt_r <= SDI_CNT_RST;
      end else if (chip_select_n_i) begin
         sdi_active_r <= 1'b0;
      end else if (ext_fall && sdi_active_r) begin
         sdi_shift_r <= {sdi_shift_r[SDI_BITS-2:0], serial_in_i};
         sdi_cnt_r <= sdi_cnt_r + 5'h01;
         if (sdi_cnt_r == 5'(SDI_BITS - 1)) begin
            sdi_active_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_in_word_o <= '0;
         serial_in_word_valid_o <= 1'b0;
      end else begin
         serial_in_word_valid_o <= 1'b0;
         if (ext_fall && sdi_active_r && !chip_select_n_i && (sdi_cnt_r == 5'(SDI_BITS - 1))) begin
            serial_in_word_o <= {sdi_shift_r[SDI_BITS-2:0], serial_in_i};
            serial_in_word_valid_o <= 1'b1;
         end
      end
   end
endmodule

/* File: rtl/result_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and registered read data.
// Assumes one clock; read data is looked ahead so it is valid with rd_valid_o.
module result_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   output logic [WIDTH-1:0] rd_data_o,
   output logic rd_valid_o,
   input wire logic rd_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW-1:0] rd_ptr_nxt;
   logic [AW:0] count_r;
   logic [AW:0] count_nxt;
   logic wr_en;
   logic rd_en;

   assign wr_en = wr_valid_i && wr_ready_o;
   assign rd_en = rd_ready_i && rd_valid_o;
   assign rd_ptr_nxt = rd_en ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;

   always_comb begin
      count_nxt = count_r;
      if (wr_en && !rd_en) begin
         count_nxt = count_r + 1'b1;
      end else if (rd_en && !wr_en) begin
         count_nxt = count_r - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (wr_en) begin
         mem_r[wr_ptr_r] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         wr_ready_o <= 1'b1;
         rd_valid_o <= 1'b0;
      end else begin
         if (wr_en) begin
            wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
         end
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
         wr_ready_o <= (count_nxt != (AW+1)'(DEPTH));
         rd_valid_o <= (count_nxt != '0);
      end
   end

   // Bypass covers a write landing on the slot about to be read
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o <= '0;
      end else if (wr_en && (wr_ptr_r == rd_ptr_nxt)) begin
         rd_data_o <= wr_data_i;
      end else begin
         rd_data_o <= mem_r[rd_ptr_nxt];
      end
   end
endmodule

/* File: rtl/sar_core.sv */
// Successive-approximation engine for all channels, one bit per step pulse.
// Assumes the held sample is stable from load until the last step.
module sar_core #(
   parameter int RES_BITS = 12,
   parameter int CHANNELS = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic step_i,
   input wire logic [CHANNELS-1:0][RES_BITS-1:0] held_i,
   output logic [CHANNELS-1:0][RES_BITS-1:0] result_o
);
   logic [RES_BITS-1:0] bit_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bit_r <= '0;
      end else if (load_i) begin
         bit_r <= {1'b1, {(RES_BITS-1){1'b0}}};
      end else if (step_i) begin
         bit_r <= bit_r >> 1;
      end
   end

   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      logic [RES_BITS-1:0] trial;
      assign trial = result_o[ch] | bit_r;
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            result_o[ch] <= '0;
         end else if (load_i) begin
            result_o[ch] <= '0;
         end else if (step_i && (bit_r != '0) && (trial <= held_i[ch])) begin
            result_o[ch] <= trial;
         end
      end
   end
endmodule

/* File: shared/sar_adc_pkg.sv */
// Constants, types and enumerations shared by the dual SAR serial controller.
// Assumes a single system clock at 25 MHz; all pins are synchronous to it.
// What this block does
// - Trigger rise puts both channels in hold
// - Conversion starts at next external clock rise
// - Busy high while held, low when done
// - Busy follows trigger except in automatic standby
// - Busy falls on an external clock rise
// - Chip select low drives outputs, else released
// - Read strobe frames both directions; needs select
// - Read strobe sampled on external clock falls
// - Serial input captured on external clock falls
// - Output bits change after external clock rise, except B parking low when output select falls
// - Output select high: A and B in parallel
// - Input select picks converted channel pair
package sar_adc_pkg;

   localparam int RES_BITS = 12;
   localparam int CHANNELS = 2;
   localparam int CONV_CYCLES = 13;
   localparam int ACQ_CYCLES = 2;
   localparam int SDI_BITS = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int SYS_CLK_PERIOD_NS = 40;
   localparam int FRAME_BITS = 2 * RES_BITS;

   localparam logic [3:0] CONV_CNT_RST = 4'h0;
   localparam logic [1:0] ACQ_CNT_RST = 2'h0;
   localparam logic [4:0] SDI_CNT_RST = 5'h00;

   typedef struct packed {
      logic [RES_BITS-1:0] a;
      logic [RES_BITS-1:0] b;
   } result_pair_type;

   typedef enum logic [4:0] {
      ST_IDLE    = 5'b0_0001,
      ST_HOLD    = 5'b0_0010,
      ST_CONVERT = 5'b0_0100,
      ST_STALL   = 5'b0_1000,
      ST_ACQUIRE = 5'b1_0000
   } conv_state_type;

endpackage
